// *** testbench/flash_gate_properties.sv ***
// Purpose: Port checks of the flash security gate.
// Assumes: sec_o is settled once two idle edges precede a request.
// Notes: Only requests after two idle edges are judged, as the model sends them.
`timescale 1ns/1ps
module flash_gate_checker
    import flash_gate_pkg::*;
#(
    parameter int BOOT_BLOCKS = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input flash_gate_pkg::req_t req_i,
    input wire logic code_blank_i,
    input wire logic data_blank_i,
    input flash_gate_pkg::resp_t resp_o,
    input wire logic do_erase_o,
    input wire logic do_write_o,
    input wire logic [flash_gate_pkg::SEC_W-1:0] sec_o
);
    logic [1:0] hist_reg;
    logic go, ser, low;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) hist_reg <= 2'h0;
        else hist_reg <= {hist_reg[0], req_valid_i};
    end
    assign go = req_valid_i && hist_reg == 2'h0;
    assign ser = go && !req_i.self_prog;
    assign low = int'(req_i.block) < BOOT_BLOCKS;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_erase_deny: assert property (ser && req_i.cmd == CMD_ERASE && sec_o[0] && !low
        |=> !do_erase_o && resp_o.code == ANS_DENY_ERASE) else $error("erase ran");
    a_write_deny: assert property (ser && req_i.cmd == CMD_WRITE && sec_o[1] && !low
        |=> !do_write_o && resp_o.code == ANS_DENY_WRITE) else $error("write ran");
    a_boot_deny: assert property (go && !req_i.cmd[1] && sec_o[2] && low
        |=> !do_erase_o && !do_write_o && resp_o.code == ANS_DENY_BOOT) else $error("boot hit");
    a_self_free: assert property (go && req_i.self_prog && !req_i.cmd[1] && !low
        |=> resp_o.granted && (do_erase_o || do_write_o)) else $error("self op blocked");
    a_pro_sticky: assert property (sec_o[0] || sec_o[2]
        |=> (sec_o & $past(sec_o) & 3'h5) == ($past(sec_o) & 3'h5)) else $error("guard lost");
    a_clear_rule: assert property (ser && req_i.cmd == CMD_CLR_WPRO
        |=> resp_o.granted == (($past(sec_o) & 3'h5) == 3'h0 && $past(code_blank_i)
        && $past(data_blank_i))) else $error("clear decision wrong");
    a_self_clear: assert property (go && req_i.self_prog && req_i.cmd == CMD_CLR_WPRO
        |=> !resp_o.granted && resp_o.code == ANS_DENY_CLEAR) else $error("self clear ran");
    a_idle_quiet: assert property (!req_valid_i
        |=> !resp_o.valid && !do_erase_o && !do_write_o) else $error("pulse without request");
endmodule : flash_gate_checker
bind flash_security_gate flash_gate_checker #(.BOOT_BLOCKS(BOOT_BLOCKS)) checker_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .code_blank_i(code_blank_i), .data_blank_i(data_blank_i), .resp_o(resp_o),
    .do_erase_o(do_erase_o), .do_write_o(do_write_o), .sec_o(sec_o));

// *** testbench/prog_model.sv ***
// Purpose: Request source for the gate, standing in for programmer or firmware.
// Assumes: Two idle edges precede each request, so settings have settled.
// Notes: Idle fields are inverted so stale values never pass as live.
`timescale 1ns/1ps
module prog_model
    import flash_gate_pkg::*;
(
    input wire logic clk_sys_i,
    output logic req_valid_o,
    output flash_gate_pkg::req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // Callers only write blocks known to be blank.
    task automatic send(input cmd_t c, input logic p, input logic [7:0] b);
        repeat (2) @(posedge clk_sys_i);
        #1;
        req_valid_o = 1'b1;
        req_o = '{c, p, b, b[2:0]};
        @(posedge clk_sys_i);
        #1;
        req_valid_o = 1'b0;
        req_o = ~req_o;
    endtask : send
endmodule : prog_model

// *** testbench/tb.sv ***
// Purpose: Directed scenarios for the flash security gate.
// Assumes: The request model leaves two idle edges before each request.
// Notes: Settings persist, so each scenario builds on the last.
`timescale 1ns/1ps
module tb;
    import flash_gate_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic data_blank_i = 1'b1;
    logic code_blank_i = 1'b1;
    logic [BLOCK_W-1:0] block_o;
    logic req_valid_i, do_erase_o, do_write_o;
    req_t req_i;
    resp_t resp_o;
    logic [SEC_W-1:0] sec_o;
    int error_cnt = 0;
    int checks = 0;
    flash_security_gate #(.BOOT_BLOCKS(1)) flash_security_gate_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i), .code_blank_i(code_blank_i),
        .data_blank_i(data_blank_i), .resp_o(resp_o), .do_erase_o(do_erase_o),
        .do_write_o(do_write_o), .block_o(block_o), .sec_o(sec_o));
    prog_model prog_model_inst (.clk_sys_i(clk_sys_i), .req_valid_o(req_valid_i), .req_o(req_i));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // Expected word is valid, granted, answer code, erase pulse, write pulse.
    task automatic op(input cmd_t c, input logic p, input logic [7:0] b, input logic [6:0] e);
        prog_model_inst.send(c, p, b);
        check("response", {1'b0, resp_o, do_erase_o, do_write_o}, {1'b0, e});
        check("block", block_o, b);
    endtask : op
    task automatic sec_is(input logic [2:0] s);
        @(posedge clk_sys_i);
        #1;
        check("settings", {5'h00, sec_o}, {5'h00, s});
    endtask : sec_is
    task automatic t_write_pro();
        sec_is(3'h0);
        op(CMD_CLR_WPRO, 1'b1, 8'h08, 7'h50);
        op(CMD_SET_SEC, 1'b0, 8'h02, 7'h60);
        op(CMD_ERASE, 1'b0, 8'h05, 7'h62);
        op(CMD_WRITE, 1'b0, 8'h05, 7'h48);
        op(CMD_WRITE, 1'b1, 8'h05, 7'h61);
        data_blank_i = 1'b0;
        op(CMD_CLR_WPRO, 1'b0, 8'h08, 7'h50);
        data_blank_i = 1'b1;
        code_blank_i = 1'b0;
        op(CMD_CLR_WPRO, 1'b0, 8'h08, 7'h50);
        code_blank_i = 1'b1;
        op(CMD_CLR_WPRO, 1'b0, 8'h08, 7'h60);
        sec_is(3'h0);
        $display("test t_write_pro done");
    endtask : t_write_pro
    task automatic t_erase_pro();
        op(CMD_SET_SEC, 1'b0, 8'h01, 7'h60);
        op(CMD_ERASE, 1'b0, 8'h05, 7'h44);
        op(CMD_WRITE, 1'b0, 8'h06, 7'h61);
        op(CMD_SET_SEC, 1'b0, 8'h02, 7'h60);
        op(CMD_CLR_WPRO, 1'b0, 8'h08, 7'h50);
        op(CMD_ERASE, 1'b1, 8'h05, 7'h62);
        op(CMD_SET_SEC, 1'b0, 8'h08, 7'h60);
        sec_is(3'h3);
        $display("test t_erase_pro done");
    endtask : t_erase_pro
    task automatic t_boot_pro();
        op(CMD_SET_SEC, 1'b0, 8'h04, 7'h60);
        op(CMD_ERASE, 1'b0, 8'h00, 7'h4C);
        op(CMD_ERASE, 1'b1, 8'h00, 7'h4C);
        op(CMD_WRITE, 1'b1, 8'h00, 7'h4C);
        op(CMD_WRITE, 1'b1, 8'h01, 7'h61);
        sec_is(3'h7);
        $display("test t_boot_pro done");
    endtask : t_boot_pro
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        t_write_pro();
        t_erase_pro();
        t_boot_pro();
        test_done();
    end
endmodule : tb

// *** verilog/flash_gate_pkg.sv ***
// Purpose: Shared types and constants for the flash security gate.
// Assumes: One clock domain; commands arrive as one-cycle requests.
// Notes: Security settings are held in a small register image module that clears on reset.
package flash_gate_pkg;

    // ----------------------------------------------------------------
    // Command encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_ERASE    = 2'h0,
        CMD_WRITE    = 2'h1,
        CMD_SET_SEC  = 2'h2,
        CMD_CLR_WPRO = 2'h3
    } cmd_t;

    typedef enum logic [2:0] {
        ANS_DONE       = 3'h0,
        ANS_DENY_ERASE = 3'h1,
        ANS_DENY_WRITE = 3'h2,
        ANS_DENY_BOOT  = 3'h3,
        ANS_DENY_CLEAR = 3'h4
    } ans_t;

    // ----------------------------------------------------------------
    // Security setting layout
    // ----------------------------------------------------------------
    localparam int SEC_W = 3;
    localparam int SEC_ERASE_PRO_BIT = 0;
    localparam int SEC_WRITE_PRO_BIT = 1;
    localparam int SEC_BOOT_PRO_BIT = 2;
    localparam logic [2:0] SEC_RESET = 3'h0;
    localparam int BLOCK_W = 8;

    typedef struct packed {
        cmd_t cmd;
        logic self_prog;
        logic [7:0] block;
        logic [2:0] sec_bits;
    } req_t;

    typedef struct packed {
        logic valid;
        logic granted;
        ans_t code;
    } resp_t;

endpackage : flash_gate_pkg

// *** verilog/flash_security_gate.sv ***
// Purpose: Decides whether flash erase, write and security commands are carried out.
// Assumes: Requests are one-cycle pulses from logic on the same clock.
// Notes: Self-programming protection otherwise comes from a separate window unit.
`timescale 1ns/1ps
module flash_security_gate #(
    parameter int BOOT_BLOCKS = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input flash_gate_pkg::req_t req_i,
    input wire logic code_blank_i,
    input wire logic data_blank_i,
    output flash_gate_pkg::resp_t resp_o,
    output logic do_erase_o,
    output logic do_write_o,
    output logic [flash_gate_pkg::BLOCK_W-1:0] block_o,
    output logic [flash_gate_pkg::SEC_W-1:0] sec_o
);
    import flash_gate_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // The boot area starts at block 0 and must fit inside the block index,
    // otherwise boot protection could never be reached or would cover nothing.
    if (BOOT_BLOCKS < 1) begin : g_boot_too_small
        $error("BOOT_BLOCKS must be at least one");
    end
    if (BOOT_BLOCKS > (1 << BLOCK_W)) begin : g_boot_too_large
        $error("BOOT_BLOCKS exceeds the block index range");
    end
    // Three setting bits are decoded below at fixed places.
    if (SEC_W < 3) begin : g_sec_too_narrow
        $error("SEC_W must hold three setting bits");
    end

    // ----------------------------------------------------------------
    // Settings image
    // ----------------------------------------------------------------
    logic [SEC_W-1:0] sec_cur;
    logic sec_wr;
    logic [SEC_W-1:0] sec_next;

    // The image resets to all clear; settings are raised only through the
    // set command, so a fresh part starts without any protection.
    sec_store #(.WIDTH(SEC_W)) u_store (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(sec_wr),
        .wr_data_i(sec_next),
        .rd_data_o(sec_cur)
    );

    function automatic logic in_boot(input logic [BLOCK_W-1:0] blk);
        in_boot = (32'(blk) < BOOT_BLOCKS);
    endfunction : in_boot

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // The erase and write prohibitions bind only while an external programmer
    // drives the sequencer; firmware relies on its own protected window instead.
    function automatic logic mode_blocks(input logic pro, input logic self_prog);
        mode_blocks = pro && !self_prog;
    endfunction : mode_blocks

    // Clearing the write prohibition is the only way a setting bit can drop,
    // so every condition for it is gathered in this one place.
    function automatic logic clear_ok(
        input logic [SEC_W-1:0] sec,
        input logic self_prog,
        input logic code_blank,
        input logic data_blank
    );
        clear_ok = !self_prog
            && !sec[SEC_ERASE_PRO_BIT]
            && !sec[SEC_BOOT_PRO_BIT]
            && code_blank
            && data_blank;
    endfunction : clear_ok

    function automatic logic [SEC_W-1:0] drop_write_pro(input logic [SEC_W-1:0] sec);
        drop_write_pro = sec & ~(SEC_W'(1) << SEC_WRITE_PRO_BIT);
    endfunction : drop_write_pro

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    // Fields are meaningful only while the strobe is high; every action below
    // is qualified by it, so idle values on the request bus can never act.
    logic take_any;
    logic take_erase;
    logic take_write;

    assign take_any = req_valid_i;
    assign take_erase = req_valid_i && req_i.cmd == CMD_ERASE;
    assign take_write = req_valid_i && req_i.cmd == CMD_WRITE;

    // ----------------------------------------------------------------
    // Decision
    // ----------------------------------------------------------------
    logic erase_pro;
    logic write_pro;
    logic boot_pro;
    logic grant;
    ans_t code;

    assign erase_pro = sec_cur[SEC_ERASE_PRO_BIT];
    assign write_pro = sec_cur[SEC_WRITE_PRO_BIT];
    assign boot_pro = sec_cur[SEC_BOOT_PRO_BIT];

    // Boot protection is judged first in every mode, so a boot-area request
    // reports the boot denial even when a serial prohibition also applies.
    always_comb begin
        grant = 1'b1;
        code = ANS_DONE;
        sec_wr = 1'b0;
        sec_next = sec_cur;
        unique case (req_i.cmd)
            CMD_ERASE: begin
                if (boot_pro && in_boot(req_i.block)) begin
                    grant = 1'b0;
                    code = ANS_DENY_BOOT;
                end else if (mode_blocks(erase_pro, req_i.self_prog)) begin
                    grant = 1'b0;
                    code = ANS_DENY_ERASE;
                end
            end
            CMD_WRITE: begin
                if (boot_pro && in_boot(req_i.block)) begin
                    grant = 1'b0;
                    code = ANS_DENY_BOOT;
                end else if (mode_blocks(write_pro, req_i.self_prog)) begin
                    grant = 1'b0;
                    code = ANS_DENY_WRITE;
                end
            end
            CMD_SET_SEC: begin
                // Setting is additive only, so sticky bits can never drop here.
                sec_wr = req_valid_i;
                sec_next = sec_cur | req_i.sec_bits;
            end
            CMD_CLR_WPRO: begin
                if (!clear_ok(sec_cur, req_i.self_prog,
                        code_blank_i, data_blank_i)) begin
                    grant = 1'b0;
                    code = ANS_DENY_CLEAR;
                end else begin
                    sec_wr = req_valid_i;
                    sec_next = drop_write_pro(sec_cur);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registered answer
    // ----------------------------------------------------------------
    // The answer stands for exactly one cycle after each request; an idle
    // cycle returns to the all-zero word so a stale denial cannot linger.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_o <= '0;
        end else begin
            resp_o.valid <= take_any;
            resp_o.granted <= take_any && grant;
            resp_o.code <= take_any ? code : ANS_DONE;
        end
    end

    // Action pulses reach the sequencer only for granted erase and write
    // requests; security commands never start a flash operation.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            do_erase_o <= 1'b0;
        end else begin
            do_erase_o <= take_erase && grant;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            do_write_o <= 1'b0;
        end else begin
            do_write_o <= take_write && grant;
        end
    end

    // The block address holds between requests so the sequencer may read it
    // for as long as its operation runs.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_o <= '0;
        end else if (take_any) begin
            block_o <= req_i.block;
        end
    end

    // ----------------------------------------------------------------
    // Settings mirror
    // ----------------------------------------------------------------
    // The visible copy is loaded on the same edge as the image, so it never
    // shows a value that the store does not hold.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_o <= SEC_RESET;
        end else begin
            sec_o <= sec_wr ? sec_next : sec_cur;
        end
    end
endmodule : flash_security_gate

// *** verilog/sec_store.sv ***
// Purpose: Holds the current security settings image.
// Assumes: Writes come from the gate only, on the system clock.
// Notes: Read data always comes from a register.
`timescale 1ns/1ps
module sec_store #(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    output logic [WIDTH-1:0] rd_data_o
);
    if (WIDTH < 3) begin : g_width_too_small
        $error("sec_store needs at least three bits");
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else if (wr_en_i) begin
            rd_data_o <= wr_data_i;
        end
    end
endmodule : sec_store
